// ===== verilog/divide_and_loop_branch_exec.sv
// What this block does
// - divide treats A and B as unsigned bytes, quotient goes to A and remainder to B.
// - a divide with a nonzero divisor clears both carry and overflow.
// - a divide by zero sets overflow, clears carry and writes zero to both A and B.
// - the loop instruction decrements a bank register or a direct byte by one.
// - after the decrement the branch is taken if the new value is nonzero, else fall through.
// - the pc first moves past the instruction, then adds the signed offset when taken.
// - a port operand is read from its output latch, never from the pins.
// - the loop instruction takes exactly two machine cycles.
`timescale 1ns/1ps
`default_nettype none
module divide_and_loop_branch_exec
  import div_loop_pkg::*;
(
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // instruction from decode
  input  wire logic        start,
  input  wire logic [7:0]  opcode,
  input  wire logic [7:0]  operand1,
  input  wire logic [7:0]  operand2,
  input  wire logic [15:0] pcIn,
  // operands from the datapath
  input  wire logic [7:0]  accIn,
  input  wire logic [7:0]  bIn,
  input  wire logic [7:0]  bankRegIn,
  input  wire logic [7:0]  ramIn,
  input  wire logic [7:0]  portLatchIn,
  input  wire logic [7:0]  portPinIn,
  input  wire logic        portSel,
  // results
  output logic             busy,
  output logic             done,
  output logic [15:0]      pcOut,
  output logic             accWe,
  output logic [7:0]       accOut,
  output logic             bWe,
  output logic [7:0]       bOut,
  output logic             carryWe,
  output logic             carryOut,
  output logic             overflowWe,
  output logic             overflowOut,
  output logic             bankRegWe,
  output logic [2:0]       bankRegSel,
  output logic             directWe,
  output logic [7:0]       directAddr,
  output logic [7:0]       operandOut,
  output logic             branchTaken
);

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_DIV  = 3'b010,
    ST_LOOP = 3'b100
  } state_e;

  state_e     state_reg;
  logic [2:0] cyc_reg;
  logic [7:0] quot;
  logic [7:0] rem;
  logic [7:0] loopSrc;
  logic [7:0] loopDec;
  logic       isDiv;
  logic       isLoopReg;
  logic       isLoopDir;

  // decode of the opcodes this block owns
  assign isDiv     = start && (opcode == OPC_DIVIDE);
  assign isLoopReg = start && (opcode[7:3] == OPC_LOOP_REG_HI);
  assign isLoopDir = start && (opcode == OPC_LOOP_DIRECT);
  assign busy      = (state_reg != ST_IDLE);

  // unsigned divide; a zero divisor returns zero rather than the unknowns a raw divide gives
  assign quot = (bIn == BYTE_RESET) ? BYTE_RESET : accIn / bIn;
  assign rem  = (bIn == BYTE_RESET) ? BYTE_RESET : accIn % bIn;

  // ports read their latch so read-modify-write does not follow pin loading
  assign loopSrc = isLoopReg ? bankRegIn :
                   ((portSel && operand1 >= SFR_BASE) ? portLatchIn : ramIn);
  assign loopDec = loopSrc - 8'h01;

  // sequencing: hold busy for one cycle less than the instruction's cycle count
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      cyc_reg   <= 3'h0;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          if (isDiv) begin
            state_reg <= ST_DIV;
            cyc_reg   <= CYC_DIVIDE - 3'h1;
          end else if (isLoopReg || isLoopDir) begin
            state_reg <= ST_LOOP;
            cyc_reg   <= CYC_LOOP - 3'h1;
          end
        end
        ST_DIV, ST_LOOP: begin
          if (cyc_reg == 3'h1) begin
            state_reg <= ST_IDLE;
          end
          cyc_reg <= cyc_reg - 3'h1;
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // done pulses in the last cycle of each instruction
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      done <= 1'b0;
    end else begin
      done <= busy && (cyc_reg == 3'h1);
    end
  end

  // divide results and flags, captured at start, written back at completion
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      accOut      <= BYTE_RESET;
      bOut        <= BYTE_RESET;
      overflowOut <= 1'b0;
      carryOut    <= 1'b0;
    end else if (isDiv && !busy) begin
      accOut      <= quot;
      bOut        <= rem;
      overflowOut <= (bIn == BYTE_RESET);
      carryOut    <= 1'b0;
    end
  end

  // divide write enables fire together in the final cycle
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      accWe      <= 1'b0;
      bWe        <= 1'b0;
      carryWe    <= 1'b0;
      overflowWe <= 1'b0;
    end else begin
      accWe      <= (state_reg == ST_DIV) && (cyc_reg == 3'h1);
      bWe        <= (state_reg == ST_DIV) && (cyc_reg == 3'h1);
      carryWe    <= (state_reg == ST_DIV) && (cyc_reg == 3'h1);
      overflowWe <= (state_reg == ST_DIV) && (cyc_reg == 3'h1);
    end
  end

  // loop operand write-back and branch decision
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      bankRegWe   <= 1'b0;
      directWe    <= 1'b0;
      bankRegSel  <= 3'h0;
      directAddr  <= BYTE_RESET;
      operandOut  <= BYTE_RESET;
      branchTaken <= 1'b0;
    end else if (!busy && (isLoopReg || isLoopDir)) begin
      bankRegWe   <= isLoopReg;
      directWe    <= isLoopDir;
      bankRegSel  <= opcode[2:0];
      directAddr  <= operand1;
      operandOut  <= loopDec;
      branchTaken <= (loopDec != BYTE_RESET);
    end else begin
      bankRegWe   <= 1'b0;
      directWe    <= 1'b0;
    end
  end

  // pc: step past the instruction, then add the sign-extended offset if taken
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pcOut <= PC_RESET;
    end else if (!busy && isDiv) begin
      pcOut <= pcIn + LEN_DIVIDE;
    end else if (!busy && isLoopReg) begin
      pcOut <= pcIn + LEN_LOOP_REG +
               ((loopDec != BYTE_RESET) ? {{8{operand1[7]}}, operand1} : 16'h0000);
    end else if (!busy && isLoopDir) begin
      pcOut <= pcIn + LEN_LOOP_DIRECT +
               ((loopDec != BYTE_RESET) ? {{8{operand2[7]}}, operand2} : 16'h0000);
    end
  end

  // assertions
  a_div_flags_clear: assert property (@(posedge mclk) disable iff (rst)
    (isDiv && !busy && bIn != 8'h00) |=> (!carryOut && !overflowOut))
    else $error("divide with nonzero divisor left a flag set");
  a_div_zero_ovf: assert property (@(posedge mclk) disable iff (rst)
    (isDiv && !busy && bIn == 8'h00) |=> (overflowOut && !carryOut))
    else $error("divide by zero flags wrong");
  // quotient times divisor plus remainder must rebuild the dividend
  a_div_result: assert property (@(posedge mclk) disable iff (rst)
    (isDiv && !busy && bIn != 8'h00) |=>
      ({8'h00, accOut} * {8'h00, $past(bIn)} + {8'h00, bOut} == {8'h00, $past(accIn)}) &&
      (bOut < $past(bIn)))
    else $error("divide quotient or remainder wrong");
  sequence s_loop_start;
    !busy && (isLoopReg || isLoopDir);
  endsequence
  a_loop_two_cyc: assert property (@(posedge mclk) disable iff (rst)
    s_loop_start |=> busy ##1 (!busy && done))
    else $error("loop instruction not two cycles");
  a_div_four_cyc: assert property (@(posedge mclk) disable iff (rst)
    (isDiv && !busy) |=> busy [*3] ##1 (!busy && done))
    else $error("divide not four cycles");
  a_loop_decrement: assert property (@(posedge mclk) disable iff (rst)
    s_loop_start |=> operandOut == $past(loopSrc) - 8'h01)
    else $error("loop operand not decremented by one");
  a_loop_branch: assert property (@(posedge mclk) disable iff (rst)
    s_loop_start |=> branchTaken == (operandOut != 8'h00))
    else $error("branch decision disagrees with result");
  a_loop_fallthru: assert property (@(posedge mclk) disable iff (rst)
    (isLoopReg && !busy && loopDec == 8'h00) |=> pcOut == $past(pcIn) + LEN_LOOP_REG)
    else $error("fall-through pc not advanced by two");
  a_port_latch: assert property (@(posedge mclk) disable iff (rst)
    (isLoopDir && !busy && portSel && operand1 >= SFR_BASE) |=>
      operandOut == $past(portLatchIn) - 8'h01)
    else $error("port operand not taken from latch");

endmodule : divide_and_loop_branch_exec
`default_nettype wire

// ===== verilog/div_loop_pkg.sv
package div_loop_pkg;
  // opcode encodings handled by this block
  localparam logic [7:0] OPC_DIVIDE      = 8'h84;
  localparam logic [7:0] OPC_LOOP_DIRECT = 8'hd5;
  localparam logic [4:0] OPC_LOOP_REG_HI = 5'h1b;
  // instruction lengths in bytes
  localparam logic [15:0] LEN_DIVIDE      = 16'h0001;
  localparam logic [15:0] LEN_LOOP_REG    = 16'h0002;
  localparam logic [15:0] LEN_LOOP_DIRECT = 16'h0003;
  // machine cycles per instruction, counted from the start cycle
  localparam logic [2:0] CYC_DIVIDE = 3'h4;
  localparam logic [2:0] CYC_LOOP   = 3'h2;
  // reset values
  localparam logic [15:0] PC_RESET   = 16'h0000;
  localparam logic [7:0]  BYTE_RESET = 8'h00;
  // port latch window in the direct space
  localparam logic [7:0] SFR_BASE = 8'h80;
endpackage : div_loop_pkg

// ===== verification/tb_divide_and_loop_branch_exec.sv
`timescale 1ns/1ps
`default_nettype none
module tb_divide_and_loop_branch_exec;
  import div_loop_pkg::*;
  logic mclk, rst, start, portSel, busy, done, accWe, bWe, carryWe, carryOut;
  logic overflowWe, overflowOut, bankRegWe, directWe, branchTaken;
  logic [7:0] opcode, operand1, operand2, accIn, bIn, bankRegIn, ramIn, portLatchIn;
  logic [7:0] portPinIn, accOut, bOut, directAddr, operandOut;
  logic [15:0] pcIn, pcOut;
  logic [2:0] bankRegSel;
  logic [31:0] seed;
  int miscompares, total_checks;
  divide_and_loop_branch_exec u_divide_and_loop_branch_exec (
    .mclk        (mclk),
    .rst         (rst),
    .start       (start),
    .opcode      (opcode),
    .operand1    (operand1),
    .operand2    (operand2),
    .pcIn        (pcIn),
    .accIn       (accIn),
    .bIn         (bIn),
    .bankRegIn   (bankRegIn),
    .ramIn       (ramIn),
    .portLatchIn (portLatchIn),
    .portPinIn   (portPinIn),
    .portSel     (portSel),
    .busy        (busy),
    .done        (done),
    .pcOut       (pcOut),
    .accWe       (accWe),
    .accOut      (accOut),
    .bWe         (bWe),
    .bOut        (bOut),
    .carryWe     (carryWe),
    .carryOut    (carryOut),
    .overflowWe  (overflowWe),
    .overflowOut (overflowOut),
    .bankRegWe   (bankRegWe),
    .bankRegSel  (bankRegSel),
    .directWe    (directWe),
    .directAddr  (directAddr),
    .operandOut  (operandOut),
    .branchTaken (branchTaken)
  );
  // free-running clock, 8 ns period
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic print_verdict;
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : print_verdict
  // one instruction: latch and ram differ, pins carry the inverse so a pin read shows
  task automatic run(input logic [7:0] op, o1, o2, a, b, r, input logic ps, input logic [15:0] pc);
    logic [7:0] src, res, rel;
    logic [15:0] pcx;
    logic dir;
    int n;
    dir = (op == OPC_LOOP_DIRECT);
    src = (dir && ps && o1 >= SFR_BASE) ? (r ^ 8'h5a) : r;
    res = src - 8'h01;
    rel = dir ? o2 : o1;
    @(posedge mclk);
    opcode <= op;
    operand1 <= o1;
    operand2 <= o2;
    accIn <= a;
    bIn <= b;
    pcIn <= pc;
    bankRegIn <= r;
    ramIn <= r;
    portLatchIn <= r ^ 8'h5a;
    portPinIn <= ~r;
    portSel <= ps;
    start <= 1'b1;
    // the design takes start at this edge; look in the first cycle after it
    @(posedge mclk);
    start <= 1'b0;
    #1;
    chk(busy, 1'b1);
    if (op == OPC_DIVIDE) begin
      chk(pcOut, pc + LEN_DIVIDE);
      chk(carryOut, 1'b0);
      chk(overflowOut, b == 8'h00);
      if (b != 8'h00) chk({accOut, bOut}, {a / b, a % b});
    end else begin
      pcx = pc + (dir ? LEN_LOOP_DIRECT : LEN_LOOP_REG);
      if (res != 8'h00) pcx = pcx + {{8{rel[7]}}, rel};
      chk(operandOut, res);
      chk(branchTaken, res != 8'h00);
      chk(pcOut, pcx);
      chk({bankRegWe, directWe}, {~dir, dir});
      if (dir) chk(directAddr, o1);
      else chk(bankRegSel, op[2:0]);
    end
    n = 1;
    while (done !== 1'b1 && n < 8) begin
      @(posedge mclk);
      #1;
      n++;
    end
    chk(n, (op == OPC_DIVIDE) ? CYC_DIVIDE : CYC_LOOP);
    chk(busy, 1'b0);
    if (op == OPC_DIVIDE) chk({accWe, bWe, carryWe, overflowWe}, 4'hf);
    else chk({accWe, bWe, carryWe, overflowWe, bankRegWe, directWe}, 6'h00);
    $display("test op %h done", op);
  endtask : run
  // watchdog well beyond the expected run length
  initial begin
    #200000;
    miscompares++;
    print_verdict();
  end
  initial begin
    {start, portSel, opcode, operand1, operand2, accIn, bIn} = '0;
    {bankRegIn, ramIn, portLatchIn, portPinIn, pcIn} = '0;
    miscompares = 0;
    total_checks = 0;
    seed = 32'h21bdd2de;
    rst = 1'b1;
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    run(OPC_DIVIDE, 8'h00, 8'h00, 8'hfb, 8'h12, 8'h00, 1'b0, 16'h1000);
    run(OPC_DIVIDE, 8'h00, 8'h00, 8'h37, 8'h00, 8'h00, 1'b0, 16'hfffe);
    run(8'hdf, 8'hfe, 8'h00, 8'h00, 8'h00, 8'h01, 1'b0, 16'h0200);
    run(8'hd8, 8'h80, 8'h00, 8'h00, 8'h00, 8'h00, 1'b0, 16'h0010);
    run(OPC_LOOP_DIRECT, 8'h90, 8'h05, 8'h00, 8'h00, 8'h5b, 1'b1, 16'h0300);
    run(OPC_LOOP_DIRECT, 8'h40, 8'hf0, 8'h00, 8'h00, 8'h01, 1'b0, 16'h0400);
    repeat (60) begin
      seed = lfsr(seed);
      run(seed[1:0] == 2'h0 ? OPC_DIVIDE : seed[1:0] == 2'h1 ? OPC_LOOP_DIRECT
          : {OPC_LOOP_REG_HI, seed[4:2]}, seed[15:8], seed[23:16], seed[31:24],
          seed[13:6], seed[21:14], seed[5], seed[27:12]);
    end
    print_verdict();
  end
endmodule : tb_divide_and_loop_branch_exec
`default_nettype wire
